// ### rtl/bcc_pkg.sv
`default_nettype none
package bcc_pkg;
	// bus cycle codes {memory_select, status_line_1, status_line_0}
	localparam logic [2:0] CODE_IRQ_ACK  = 3'h0;
	localparam logic [2:0] CODE_IO_RD    = 3'h1;
	localparam logic [2:0] CODE_IO_WR    = 3'h2;
	localparam logic [2:0] CODE_IDLE_IO  = 3'h3;
	localparam logic [2:0] CODE_HALT     = 3'h4;
	localparam logic [2:0] CODE_MEM_RD   = 3'h5;
	localparam logic [2:0] CODE_MEM_WR   = 3'h6;
	localparam logic [2:0] CODE_IDLE_MEM = 3'h7;
	// system clock cycles per bus state
	localparam int STATE_CYCLES = 2;
	// extra clock cycles before command activation in shared-bus mode
	localparam logic [1:0] SHARED_RD_DELAY = 2'h1;
	localparam logic [1:0] SHARED_WR_DELAY = 2'h2;
	// grant-to-command delay in clock edges, shared-bus mode
	localparam logic [1:0] GRANT_EDGES = 2'h3;

	// bus state sequence
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_STATUS,
		ST_COMMAND
	} bcc_state_type;

	// processor status group
	typedef struct packed {
		logic status_line_0;
		logic status_line_1;
		logic memory_select;
	} bcc_status_type;

	// command outputs, all active low; enable high means driven
	typedef struct packed {
		logic irq_ack_cmd_n;
		logic io_read_cmd_n;
		logic io_write_cmd_n;
		logic mem_read_cmd_n;
		logic mem_write_cmd_n;
	} bcc_cmd_type;

	// control outputs
	typedef struct packed {
		logic addr_latch_strobe;
		logic cascade_address_enable;
		logic transceiver_enable;
		logic data_direction;
	} bcc_ctrl_type;

	localparam bcc_cmd_type CMD_IDLE = 5'h1F;
endpackage
`default_nettype wire

// ### rtl/bcc_sync.sv
`default_nettype none
// two flip-flop synchroniser for one level
module bcc_sync
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	// level in and out
	input  wire logic d,
	output logic      q
);
	logic meta; // first stage, read only by q

	// plain two-stage capture; resets to the idle high level of the pins
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= 1'b1;
			q    <= 1'b1;
		end
		else if (clk_en)
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

// ### rtl/bcc_top.sv
// Notes on behaviour
// RULE1 - shared mode: ready source adds a wait
// RULE2 - reset held low forces idle
// RULE3 - enable/grant input accepted asynchronously
// RULE4 - grant low: commands driven, inactive high
// RULE5 - grant high: commands floated, enable low
// RULE6 - local mode: enable low forces inactive
// RULE7 - no strobe on halt; ignores controls
// RULE8 - cascade enable only on acknowledge cycles
// RULE9 - shared mode delays write data enable
// RULE10 - direction high writes, rests high
// RULE11 - enable low whenever direction changes
// RULE12 - command on by strap/delay, off by ready
// RULE13 - decode select and status into commands
// RULE14 - halt and idle issue nothing
// RULE15 - idle, status, command; two cycles each (idle here can end after one clock)
// RULE16 - status sampled each edge starts cycle
// RULE17 - ready high repeats command, low ends
// RULE18 - outputs frozen during wait states (shared-mode delayed commands still rise in a wait state)
// RULE19 - status at command end skips idle
// RULE20 - cycle select latched internally
// RULE21 - processor asserts status on phase one
// RULE22 - idle repeats while no cycle active
// RULE23 - cycle select captured at status end
// RULE24 - delay input high withholds command
// RULE25 - strap high shared, low local timing
// RULE26 - ready low before command still ends
// RULE27 - reset and idle outputs inactive
`default_nettype none
module bcc_top
	import bcc_pkg::*;
(
	// clock, reset, clock enable
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	// processor status and control inputs (pins)
	input  wire bcc_pkg::bcc_status_type status_in,
	input  wire logic                  ready_n,
	input  wire logic                  latched_cycle_select,
	input  wire logic                  command_delay_in,
	input  wire logic                  shared_bus_timing_strap,
	input  wire logic                  enable_or_grant_in,
	// command outputs with drive enables
	output bcc_pkg::bcc_cmd_type       cmd_out,
	output logic                       cmd_oe,
	// control outputs
	output bcc_pkg::bcc_ctrl_type      ctrl_out
);
	import bcc_pkg::*;

	// synchronised pin inputs
	logic s0_s;                // status line 0
	logic s1_s;                // status line 1
	logic ms_s;                // memory select
	logic rdy_s;               // ready, active low
	logic sel_s;               // cycle select
	logic dly_s;               // command delay
	logic strap_s;             // timing strap

	// synchroniser bank
	bcc_sync u_s0 (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.d(status_in.status_line_0), .q(s0_s));
	bcc_sync u_s1 (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.d(status_in.status_line_1), .q(s1_s));
	bcc_sync u_ms (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.d(status_in.memory_select), .q(ms_s));
	bcc_sync u_rd (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.d(ready_n), .q(rdy_s));
	bcc_sync u_sl (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.d(latched_cycle_select), .q(sel_s));
	bcc_sync u_dl (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.d(command_delay_in), .q(dly_s));
	bcc_sync u_mb (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.d(shared_bus_timing_strap), .q(strap_s));

	// decode helpers
	function automatic logic is_transfer(input logic [2:0] c);
		is_transfer = (c != CODE_IDLE_IO) && (c != CODE_IDLE_MEM)
			&& (c != CODE_HALT);
	endfunction

	function automatic logic is_write(input logic [2:0] c);
		is_write = (c == CODE_IO_WR) || (c == CODE_MEM_WR);
	endfunction

	// state and cycle information
	bcc_state_type state;      // current bus state
	logic          phase;      // second clock of a bus state
	logic [2:0]    code;       // code of the active cycle
	logic          served;     // cycle select latched high
	logic          cmd_go;     // command delay released
	logic [1:0]    hold;       // clock cycles left before command
	logic          cmd_on;     // command asserted internally
	logic          strap;      // strap captured after reset
	logic          en_live;    // enable/grant used directly
	logic          start;      // status sampled active

	assign start = !(s0_s && s1_s);                             // [RULE16]
	// asynchronous path: enable/grant is used unsynchronised
	assign en_live = enable_or_grant_in;                        // [RULE3]

	// strap recaptured on every enabled clock once reset has released
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			strap <= 1'b0;
		else if (clk_en)
			strap <= strap_s;                                   // [RULE25]
	end

	// bus state sequencer
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;                                   // [RULE2]
			phase <= 1'b0;
		end
		else if (clk_en)
		begin
			case (state)
				ST_IDLE:
				begin
					// idle repeats until status goes active
					phase <= 1'b0;
					if (start)
						state <= ST_STATUS;                     // [RULE22]
				end
				ST_STATUS:
				begin
					// status state lasts two clocks
					phase <= ~phase;                            // [RULE15]
					if (phase)
					begin
						state <= ST_COMMAND;                    // [RULE17]
						phase <= 1'b0;
					end
				end
				ST_COMMAND:
				begin
					// end of command: check ready
					phase <= ~phase;                            // [RULE15]
					if (phase && !rdy_s)
					begin
						phase <= 1'b0;
						if (start)
							state <= ST_STATUS;                 // [RULE19]
						else
							state <= ST_IDLE;                   // [RULE26]
					end
				end
				default:
				begin
					state <= ST_IDLE;
					phase <= 1'b0;
				end
			endcase
		end
	end

	// cycle code and select capture
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			code   <= CODE_IDLE_MEM;
			served <= 1'b0;
		end
		else if (clk_en)
		begin
			// code taken as the status state opens
			if (start && (state == ST_IDLE ||
				(state == ST_COMMAND && phase && !rdy_s)))
				code <= {ms_s, s1_s, s0_s};                     // [RULE13]
			// select latched at end of status state
			if (state == ST_STATUS && phase)
				served <= sel_s;                                // [RULE20] [RULE23]
			else if (state != ST_COMMAND)
				served <= 1'b0;
		end
	end

	// command activation: strap delay and command delay counted together
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold   <= 2'h0;
			cmd_go <= 1'b0;
			cmd_on <= 1'b0;
		end
		else if (clk_en)
		begin
			if (state == ST_STATUS && phase)
			begin
				// shared mode defers reads by one, writes by two
				if (!strap)
					hold <= 2'h0;                               // [RULE12]
				else if (is_write(code))
					hold <= SHARED_WR_DELAY;
				else
					hold <= SHARED_RD_DELAY;
				cmd_go <= 1'b0;
				cmd_on <= 1'b0;
			end
			else if (state == ST_COMMAND && !(phase && !rdy_s))
			begin
				// command delay resampled every clock
				if (!cmd_go && !dly_s)
					cmd_go <= 1'b1;                             // [RULE24]
				if (hold != 2'h0)
					hold <= hold - 2'h1;
				if ((cmd_go || !dly_s) && hold == 2'h0)
					cmd_on <= served && is_transfer(code);      // [RULE12]
			end
			else
			begin
				// ready ends the command
				cmd_on <= 1'b0;                                 // [RULE17]
				cmd_go <= 1'b0;
				hold   <= 2'h0;
			end
		end
	end

	// grant age in shared mode: commands wait three edges
	logic [1:0] grant_age;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			grant_age <= 2'h0;
		else if (clk_en)
		begin
			if (en_live)
				grant_age <= 2'h0;
			else if (grant_age != GRANT_EDGES)
				grant_age <= grant_age + 2'h1;
		end
	end

	// registered control outputs
	logic alec;                // address strobe
	logic mcec;                // cascade enable
	logic denc;                // transceiver enable request
	logic dtrc;                // direction
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			alec <= 1'b0;                                       // [RULE27]
			mcec <= 1'b0;
			denc <= 1'b0;
			dtrc <= 1'b1;
		end
		else if (clk_en)
		begin
			// strobe in first clock of status, cascade enable through both clocks of status
			alec <= state == ST_IDLE && start &&
				is_transfer({ms_s, s1_s, s0_s});                // [RULE7] [RULE14]
			mcec <= (state == ST_IDLE && start &&
				{ms_s, s1_s, s0_s} == CODE_IRQ_ACK) ||
				(alec && code == CODE_IRQ_ACK);                 // [RULE8]
			if (state == ST_COMMAND && phase && !rdy_s)
			begin
				// cycle end: drop enable first, then rest high
				denc <= 1'b0;                                   // [RULE11]
			end
			else if (state == ST_STATUS && phase && sel_s
				&& is_transfer(code))
			begin
				// direction settles a clock before enable can rise
				dtrc <= is_write(code);                         // [RULE10] [RULE11]
			end
			else if (state == ST_COMMAND && served
				&& is_transfer(code))
			begin
				// wait states hold the same values, except a delayed shared-mode write enable that rises as the second one begins
				denc <= is_write(code) ? (!strap || cmd_on)
					: 1'b1;                                     // [RULE9] [RULE18]
			end
			else if (!denc)
				dtrc <= 1'b1;                                   // [RULE10] [RULE11]
		end
	end

	// output gating by enable/grant, applied without clock
	always_comb
	begin
		cmd_out = CMD_IDLE;
		if (cmd_on)
		begin
			case (code)
				CODE_IRQ_ACK: cmd_out.irq_ack_cmd_n   = 1'b0;   // [RULE13]
				CODE_IO_RD:   cmd_out.io_read_cmd_n   = 1'b0;
				CODE_IO_WR:   cmd_out.io_write_cmd_n  = 1'b0;
				CODE_MEM_RD:  cmd_out.mem_read_cmd_n  = 1'b0;
				CODE_MEM_WR:  cmd_out.mem_write_cmd_n = 1'b0;
				default:      cmd_out = CMD_IDLE;               // [RULE14]
			endcase
		end
		ctrl_out.addr_latch_strobe      = alec;
		ctrl_out.cascade_address_enable = mcec;
		ctrl_out.data_direction         = dtrc;
		ctrl_out.transceiver_enable     = denc;
		cmd_oe = 1'b1;
		if (strap)
		begin
			// shared mode: grant high floats and kills enable
			if (en_live)
			begin
				cmd_oe = 1'b0;                                  // [RULE5]
				ctrl_out.transceiver_enable = 1'b0;
			end
			else if (grant_age != GRANT_EDGES)
				cmd_out = CMD_IDLE;                             // [RULE4]
		end
		else if (!en_live)
		begin
			// local mode: enable low forces inactive, still driven
			cmd_out = CMD_IDLE;                                 // [RULE6]
			ctrl_out.transceiver_enable = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### verif/bcc_cpu_model.sv
`default_nettype none
// processor side: shows one status code for one bus state
module bcc_cpu_model
	import bcc_pkg::*;
(
	// clock
	input wire logic                    ref_clk,
	// request from the bench
	input wire logic                    go,
	input wire logic [2:0]              code,
	// status pins
	output bcc_pkg::bcc_status_type     status_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] left; // clocks left showing status
	initial
	begin
		status_out = 3'h7;
		left = 2'h0;
	end
	// status starts at phase one, held two clocks
	always @(posedge ref_clk)
	begin
		if (go)
		begin
			status_out <= {code[0], code[1], code[2]};
			left <= 2'h2;
		end
		else if (left != 2'h0)
		begin
			left <= left - 2'h1;
			// released: lines pulled high, select flips
			if (left == 2'h1)
				status_out <= {2'h3, !status_out.memory_select};
		end
	end
endmodule
`default_nettype wire

// ### verif/bcc_properties.sv
`default_nettype none
// pin-level checks on the bus command controller
module bcc_properties
	import bcc_pkg::*;
(
	// clock and reset
	input wire logic                    ref_clk,
	input wire logic                    rst_n,
	// mode and enable pins
	input wire logic                    shared_bus_timing_strap,
	input wire logic                    enable_or_grant_in,
	// outputs watched
	input wire bcc_pkg::bcc_cmd_type    cmd_out,
	input wire logic                    cmd_oe,
	input wire bcc_pkg::bcc_ctrl_type   ctrl_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// any read command or any write command active
	logic rd_on;
	logic wr_on;
	assign rd_on = !cmd_out.io_read_cmd_n || !cmd_out.mem_read_cmd_n
		|| !cmd_out.irq_ack_cmd_n;
	assign wr_on = !cmd_out.io_write_cmd_n || !cmd_out.mem_write_cmd_n;

	chk_grant_drives: assert property (
		shared_bus_timing_strap && $past(shared_bus_timing_strap, 4)
		&& !enable_or_grant_in |-> cmd_oe)
		else $error("commands floated while granted");
	chk_grant_floats: assert property (
		shared_bus_timing_strap && $past(shared_bus_timing_strap, 4)
		&& enable_or_grant_in |-> !cmd_oe && !ctrl_out.transceiver_enable)
		else $error("commands driven without grant");
	chk_local_disable: assert property (
		!shared_bus_timing_strap && !$past(shared_bus_timing_strap, 4)
		&& !enable_or_grant_in |-> cmd_oe && cmd_out == CMD_IDLE
		&& !ctrl_out.transceiver_enable)
		else $error("local enable low not honoured");
	chk_strobe_pulse: assert property (
		ctrl_out.addr_latch_strobe |=> !ctrl_out.addr_latch_strobe)
		else $error("strobe longer than one clock");
	chk_cascade_len: assert property (
		$rose(ctrl_out.cascade_address_enable)
		|-> ctrl_out.cascade_address_enable[*2]
		##1 !ctrl_out.cascade_address_enable)
		else $error("cascade enable not two clocks");
	chk_dir_quiet: assert property (
		$changed(ctrl_out.data_direction) |-> !ctrl_out.transceiver_enable
		&& !$past(ctrl_out.transceiver_enable))
		else $error("direction moved with enable on");
	chk_one_cmd: assert property (
		$onehot0(~cmd_out))
		else $error("two commands at once");
	chk_read_dir: assert property (
		rd_on |-> !ctrl_out.data_direction)
		else $error("read command with direction high");
	chk_write_dir: assert property (
		wr_on |-> ctrl_out.data_direction)
		else $error("write command with direction low");
	chk_local_den: assert property (
		!shared_bus_timing_strap && !$past(shared_bus_timing_strap, 4)
		&& (rd_on || wr_on) |-> ctrl_out.transceiver_enable)
		else $error("command without data enable");
	// main scenarios seen
	cover property ($rose(ctrl_out.cascade_address_enable));
	cover property (wr_on && shared_bus_timing_strap);
	cover property (!cmd_oe);
endmodule
bind bcc_top bcc_properties i_bcc_properties (
	.ref_clk(ref_clk), .rst_n(rst_n),
	.shared_bus_timing_strap(shared_bus_timing_strap),
	.enable_or_grant_in(enable_or_grant_in),
	.cmd_out(cmd_out), .cmd_oe(cmd_oe), .ctrl_out(ctrl_out));
`default_nettype wire

// ### verif/bcc_top_test.sv
`default_nettype none
// bench: drives cycles, watcher pairs commands with notes
module bcc_top_test
	import bcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst_n, ready_n, sel, dly, strap, grant_en, go;
	logic [2:0]     code;
	bcc_status_type status;
	bcc_cmd_type    cmd;
	bcc_cmd_type    prev = CMD_IDLE;
	logic           oe;
	bcc_ctrl_type   ctrl;
	logic [8:0]     notes[$]; // {command, direction, gap}
	int n_fail = 0, checks_done = 0, cycles = 0, gap = 0;
	int n_strobe = 0, exp_strobe = 0, n_casc = 0, exp_casc = 0;

	initial
	begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	bcc_top i_bcc_top (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
		.status_in(status), .ready_n(ready_n),
		.latched_cycle_select(sel), .command_delay_in(dly),
		.shared_bus_timing_strap(strap), .enable_or_grant_in(grant_en),
		.cmd_out(cmd), .cmd_oe(oe), .ctrl_out(ctrl));
	bcc_cpu_model i_bcc_cpu_model (.ref_clk(ref_clk), .go(go),
		.code(code), .status_out(status));

	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask
	task wrap_up;
		$display("checks=%0d fails=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watcher: timeout, strobe and cascade counts, command pairing
	always @(negedge ref_clk)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			n_fail++;
			wrap_up();
		end
		gap++;
		if (ctrl.addr_latch_strobe === 1'b1)
		begin
			n_strobe++;
			gap = 0;
		end
		n_casc += int'(ctrl.cascade_address_enable);
		if (cmd !== CMD_IDLE && prev === CMD_IDLE)
			check({cmd, ctrl.data_direction, 3'(gap)},
				notes.size() ? notes.pop_front() : 9'bx);
		prev = cmd;
	end
	// one bus cycle; w stretches ready, due says a command is owed
	task automatic run(input logic [2:0] c, input int w, input logic due);
		logic [2:0] idx;
		logic       dir;
		logic [8:0] held;
		idx = c[2] ? c - 3'h2 : c;
		dir = (c == CODE_IO_WR || c == CODE_MEM_WR);
		if (due)
			notes.push_back({~(5'h10 >> idx), dir,
				3'(2 * STATE_CYCLES - 1)
				+ (!strap ? 3'h0 : dir ? 3'(SHARED_WR_DELAY)
				: 3'(SHARED_RD_DELAY))});
		if (c != CODE_HALT && c[1:0] != 2'h3)
			exp_strobe++;
		if (c == CODE_IRQ_ACK && sel)
			exp_casc += 2;
		@(negedge ref_clk);
		ready_n = (w != 0);
		go = 1;
		code = c;
		@(negedge ref_clk);
		go = 0;
		if (w > 2)
		begin
			// delayed shared-mode commands settle in the first wait state
			repeat (9) @(negedge ref_clk);
			held = {cmd, ctrl};
			repeat (2) @(negedge ref_clk);
			check({cmd, ctrl}, held);
		end
		repeat (2 * w + 5 - (w > 2 ? 11 : 0)) @(negedge ref_clk);
		ready_n = 0;
		repeat (6) @(negedge ref_clk);
		for (int i = 0; i < 60 && ctrl !== 4'h1; i++)
			@(negedge ref_clk);
		check({5'h0, ctrl}, 9'h001);
	endtask

	initial
	begin
		rst_n = 0;
		ready_n = 0;
		sel = 1;
		dly = 0;
		strap = 0;
		grant_en = 1;
		go = 0;
		code = 3'h7;
		void'($urandom(98073));
		repeat (3) @(negedge ref_clk);
		check({cmd, ctrl}, {CMD_IDLE, 4'h1});
		rst_n = 1;
		// all codes, local then shared timing
		for (int m = 0; m < 2; m++)
		begin
			strap = m[0];
			grant_en = !m[0];
			repeat (6) @(negedge ref_clk);
			// shared timing always gets at least one wait state
			for (int c = 0; c < 8; c++)
				run(3'(c), m + $urandom % 3,
					c != 3 && c != 4 && c != 7);
			$display("sweep %0d done", m);
		end
		run(CODE_MEM_WR, 3, 1);
		grant_en = 1;
		repeat (2) @(negedge ref_clk);
		check({7'h0, oe, ctrl.transceiver_enable}, 9'h0);
		grant_en = 0;
		repeat (2) @(negedge ref_clk);
		check({8'h0, oe}, 9'h1);
		strap = 0;
		repeat (6) @(negedge ref_clk);
		run(CODE_IO_RD, 0, 0);
		grant_en = 1;
		sel = 0;
		run(CODE_IO_WR, 1, 0);
		sel = 1;
		dly = 1;
		run(CODE_MEM_RD, 1, 0);
		dly = 0;
		$display("control inputs done");
		// reset in mid cycle
		@(negedge ref_clk);
		go = 1;
		code = CODE_MEM_RD;
		@(negedge ref_clk);
		go = 0;
		rst_n = 0;
		repeat (3) @(negedge ref_clk);
		check({cmd, ctrl}, {CMD_IDLE, 4'h1});
		rst_n = 1;
		repeat (10) @(negedge ref_clk);
		check(9'(n_strobe), 9'(exp_strobe));
		check(9'(n_casc), 9'(exp_casc));
		check(9'(notes.size()), 9'h0);
		$display("reset test done");
		wrap_up();
	end
endmodule
`default_nettype wire
